// >>> src/bbsup_ctrl.sv
// What this block does
// [R1] thermal field lowers current limit above threshold
// [R2] reset into standby; LDO bit independent
// [R3] active to standby on disable or force
// [R4] above 160 degrees disable, latch shutdown flag
// [R5] restart below 130; flag cleared on read
// [R6] overcurrent switch off, one clock behind the trip, only while it lasts
// [R7] eight consecutive limit cycles latch off
// [R8] latch cleared by disable bit or standby
// [R9] host kicks watchdog before timeout
// [R10] kick restarts count, self-clears; timeout faults
// [R11] two-bit timeout select, zero disables
// [R12] watchdog off and cleared in standby
// [R13] pin enables unless software override set
// [R14] standby force bit holds standby
// [R15] leave active on disable or long overvoltage
// [R16] setpoint is ten-bit code over two registers
// [R17] setpoint ramps at selected slew rate
// [R18] input below base minus margin restarts
// [R19] discharge sink on while lowering setpoint
// [R20] start-up delay timer before soft start
// [R21] soft start length from its own field
// [R22] interrupt on each standby entry
// [R23] interrupt on watchdog expiry, level held
// [R24] middle watchdog codes are parameters
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`include "bbsup_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module bbsup_ctrl #(
  parameter int unsigned WD_T1_S   = 80,
  parameter int unsigned WD_T2_S   = 160,
  parameter int unsigned WD_T3_S   = 240,
  parameter int unsigned WD_T4_S   = 320,
  parameter int unsigned WD_TICK   = 200000000,
  parameter int unsigned OV_LIMIT  = `OV_CYCLES,
  parameter int unsigned DLY_TICK  = 200000
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output var  logic                 s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output var  logic                 s_axi_wready,
  output var  logic [1:0]           s_axi_bresp,
  output var  logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output var  logic                 s_axi_arready,
  output var  logic [31:0]          s_axi_rdata,
  output var  logic [1:0]           s_axi_rresp,
  output var  logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 enable_pin,
  input  wire bbsup_pkg::conv_sense_s sense,
  output var  bbsup_pkg::conv_ctrl_s  ctrl,
  output var  logic                 interrupt_out_n
);
  import bbsup_pkg::*;

  // ==========================================================
  // register bus
  logic        aw_q, w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic        wr_go;
  logic [7:0]  ctrl1_q, enctl_q, rampcfg_q, uvbase_q, uvmargin_q;
  logic [9:0]  vout_code_q;
  logic        standby_force_bit_q, kick_q, int_clear_q;
  logic        thermal_shutdown_flag_q, flag_rd_clr;
  sup_state_e  state_q;
  logic        oc_latch_q, int_pend_q, wd_expired_q;

  assign wr_go = aw_q && w_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q          <= 1'b0;
      w_q           <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awaddr_q)
          `ADDR_CTRL0, `ADDR_CTRL1, `ADDR_ENCTL, `ADDR_UVMARGIN, `ADDR_RAMPCFG,
          `ADDR_VOUT_LO, `ADDR_VOUT_HI, `ADDR_UVBASE, `ADDR_INTCTL:
            s_axi_bresp <= `RESP_OKAY;
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // config registers; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1_q             <= `CTRL1_RST; // R2
      enctl_q             <= `ENCTL_RST;
      rampcfg_q           <= 8'h00;
      uvbase_q            <= `UVBASE_RST;
      uvmargin_q          <= `UVMARGIN_RST;
      vout_code_q         <= `VOUT_RST;
      standby_force_bit_q <= 1'b0;
      kick_q              <= 1'b0;
      int_clear_q         <= 1'b0;
    end else begin
      kick_q      <= 1'b0; // R10
      int_clear_q <= 1'b0;
      if (wr_go && s_axi_wstrb[0]) begin
        case (awaddr_q)
          `ADDR_CTRL0: begin
            standby_force_bit_q <= wdata_q[`C0_STANDBY]; // R3
            kick_q              <= wdata_q[`C0_KICK]; // R10
          end
          `ADDR_CTRL1:    ctrl1_q     <= wdata_q[7:0];
          `ADDR_ENCTL:    enctl_q     <= wdata_q[7:0];
          `ADDR_UVMARGIN: uvmargin_q  <= wdata_q[7:0];
          `ADDR_RAMPCFG:  rampcfg_q   <= wdata_q[7:0];
          `ADDR_VOUT_LO:  vout_code_q[7:0] <= wdata_q[7:0]; // R16
          `ADDR_VOUT_HI:  vout_code_q[9:8] <= wdata_q[1:0]; // R16
          `ADDR_UVBASE:   uvbase_q    <= wdata_q[7:0];
          `ADDR_INTCTL:   int_clear_q <= wdata_q[`INT_CLEAR];
          default: ;
        endcase
      end
    end
  end

  // read channel, one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
          `ADDR_CTRL0:    s_axi_rdata <= {31'h0, standby_force_bit_q};
          `ADDR_CTRL1:    s_axi_rdata <= {24'h0, ctrl1_q};
          `ADDR_ENCTL:    s_axi_rdata <= {24'h0, enctl_q};
          `ADDR_UVMARGIN: s_axi_rdata <= {24'h0, uvmargin_q};
          `ADDR_RAMPCFG:  s_axi_rdata <= {24'h0, rampcfg_q};
          `ADDR_VOUT_LO:  s_axi_rdata <= {24'h0, vout_code_q[7:0]};
          `ADDR_VOUT_HI:  s_axi_rdata <= {30'h0, vout_code_q[9:8]};
          `ADDR_UVBASE:   s_axi_rdata <= {24'h0, uvbase_q};
          `ADDR_STATUS:   s_axi_rdata <= {24'h0, state_q, int_pend_q, wd_expired_q,
                                          oc_latch_q, thermal_shutdown_flag_q};
          `ADDR_INTCTL:   s_axi_rdata <= 32'h0000_0000;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  assign flag_rd_clr = s_axi_arvalid && s_axi_arready && (s_axi_araddr == `ADDR_STATUS);

  // ==========================================================
  // protection
  logic       over_temp, hot_clear, thermal_hold_q, ov_long;
  logic [3:0] oc_run_q;
  logic [31:0] ov_cnt_q;
  logic       in_standby;

  assign in_standby = (state_q == ST_STANDBY);
  assign over_temp  = sense.die_temp > `TSHUT_C;
  assign hot_clear  = sense.die_temp < (`TSHUT_C - `TSHUT_HYST_C);
  assign ov_long    = ov_cnt_q >= OV_LIMIT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thermal_hold_q          <= 1'b0;
      thermal_shutdown_flag_q <= 1'b0;
    end else begin
      if (over_temp) thermal_hold_q <= 1'b1; // R4
      else if (hot_clear) thermal_hold_q <= 1'b0; // R5
      // set wins over a read clear
      if (over_temp) thermal_shutdown_flag_q <= 1'b1; // R4
      else if (flag_rd_clr) thermal_shutdown_flag_q <= 1'b0; // R5
    end
  end

  // counts limit hits per switching cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_run_q   <= 4'd0;
      oc_latch_q <= 1'b0;
    end else begin
      if (sense.cycle_start) begin
        if (sense.over_current) oc_run_q <= (oc_run_q == `OC_RUN_LEN) ? oc_run_q
                                                                   : oc_run_q + 4'd1; // R7
        else oc_run_q <= 4'd0;
      end
      if (ctrl1_q[`C1_OCDIS] || in_standby) oc_latch_q <= 1'b0; // R8
      else if (sense.cycle_start && sense.over_current && oc_run_q == `OC_RUN_LEN - 4'd1)
        oc_latch_q <= 1'b1; // R7
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) ov_cnt_q <= 32'd0;
    else if (!sense.ov_input || state_q != ST_ACTIVE) ov_cnt_q <= 32'd0;
    else if (!ov_long) ov_cnt_q <= ov_cnt_q + 32'd1; // R15
  end

  // ==========================================================
  // watchdog
  logic [31:0] wd_tick_q;
  logic [8:0]  wd_sec_q;
  logic [8:0]  wd_limit;
  logic        wd_on;

  always_comb begin
    case (ctrl1_q[`C1_WD_HI:`C1_WD_LO]) // R11 R24
      2'b01:   wd_limit = 9'(WD_T1_S);
      2'b10:   wd_limit = 9'(WD_T2_S);
      2'b11:   wd_limit = 9'(WD_T4_S);
      default: wd_limit = 9'(WD_T3_S);
    endcase
  end
  assign wd_on = (ctrl1_q[`C1_WD_HI:`C1_WD_LO] != 2'b00) && !in_standby; // R11 R12

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_tick_q    <= 32'd0;
      wd_sec_q     <= 9'd0;
      wd_expired_q <= 1'b0;
    end else if (!wd_on || kick_q) begin
      wd_tick_q <= 32'd0; // R10 R12
      wd_sec_q  <= 9'd0;
      if (kick_q || in_standby || !wd_on) wd_expired_q <= 1'b0;
    end else if (wd_sec_q >= wd_limit) begin
      wd_expired_q <= 1'b1; // R10
    end else if (wd_tick_q == WD_TICK - 1) begin
      wd_tick_q <= 32'd0;
      wd_sec_q  <= wd_sec_q + 9'd1;
    end else begin
      wd_tick_q <= wd_tick_q + 32'd1;
    end
  end

  // ==========================================================
  // enable and state machine
  logic        enabled, uv_trip, dly_done;
  logic [31:0] dly_cnt_q, dly_target;
  logic [7:0]  uv_thresh;

  assign enabled   = enctl_q[`EN_OVR] ? enctl_q[`EN_SW_EN] : enable_pin; // R13
  assign uv_thresh = uvbase_q - uvmargin_q; // R18
  assign uv_trip   = sense.vin_code < uv_thresh; // R18
  always_comb begin
    case (enctl_q[`EN_START_HI:`EN_START_LO]) // R20
      2'b00:   dly_target = 32'd0;
      2'b01:   dly_target = 32'd10 * DLY_TICK;
      2'b10:   dly_target = 32'd100 * DLY_TICK;
      default: dly_target = 32'd1000 * DLY_TICK;
    endcase
  end
  assign dly_done = dly_cnt_q >= dly_target;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q   <= ST_STANDBY; // R2
      dly_cnt_q <= 32'd0;
    end else begin
      case (state_q)
        ST_STANDBY: begin
          dly_cnt_q <= 32'd0;
          if (enabled && !standby_force_bit_q) state_q <= ST_DELAY; // R14
        end
        ST_DELAY: begin
          if (!enabled || standby_force_bit_q) state_q <= ST_STANDBY;
          else if (dly_done && !thermal_hold_q && !uv_trip && !oc_latch_q)
            state_q <= ST_ACTIVE; // R20
          else if (!dly_done) dly_cnt_q <= dly_cnt_q + 32'd1;
        end
        ST_ACTIVE: begin
          if (!enabled || standby_force_bit_q || ov_long) state_q <= ST_STANDBY; // R3 R15
          else if (wd_expired_q) state_q <= ST_FAULT; // R10
          else if (thermal_hold_q || uv_trip || oc_latch_q) begin
            state_q   <= ST_DELAY; // R4 R18
            dly_cnt_q <= 32'd0;
          end
        end
        ST_FAULT: begin
          if (!enabled || standby_force_bit_q) state_q <= ST_STANDBY;
          else if (!wd_expired_q) state_q <= ST_DELAY;
        end
        default: state_q <= ST_STANDBY;
      endcase
    end
  end

  // ==========================================================
  // interrupt
  logic was_standby_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      was_standby_q   <= 1'b1;
      int_pend_q      <= 1'b0;
      interrupt_out_n <= 1'b1;
    end else begin
      was_standby_q <= in_standby;
      if ((in_standby && !was_standby_q) || wd_expired_q) int_pend_q <= 1'b1; // R22 R23
      else if (int_clear_q) int_pend_q <= 1'b0;
      interrupt_out_n <= !int_pend_q;
    end
  end

  // ==========================================================
  // setpoint ramp and converter outputs
  logic [9:0]  ramp_q;
  logic [39:0] ramp_cnt_q, ramp_step;
  always_comb begin
    case (rampcfg_q[`RC_SLEW_HI:`RC_SLEW_LO]) // R17
      2'b00:   ramp_step = `RAMP_STEP_CYC;
      2'b01:   ramp_step = `RAMP_STEP_CYC * 40'd2;
      2'b10:   ramp_step = `RAMP_STEP_CYC * 40'd5;
      default: ramp_step = `RAMP_STEP_CYC * 40'd10;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ramp_q     <= `VOUT_RST;
      ramp_cnt_q <= 40'd0;
    end else if (ramp_q == vout_code_q) begin
      ramp_cnt_q <= 40'd0;
    end else if (ramp_cnt_q >= ramp_step - 40'd1) begin
      ramp_cnt_q <= 40'd0;
      ramp_q     <= (ramp_q < vout_code_q) ? ramp_q + 10'd1 : ramp_q - 10'd1; // R17
    end else begin
      ramp_cnt_q <= ramp_cnt_q + 40'd1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= '0;
    end else begin
      ctrl.sw_turn_off    <= sense.over_current; // R6
      ctrl.conv_enable    <= (state_q == ST_ACTIVE); // R3 R10
      ctrl.ldo_enable     <= ctrl1_q[`C1_LDO_EN]; // R2
      ctrl.soft_start     <= (state_q == ST_DELAY) && dly_done; // R21
      ctrl.soft_start_sel <= enctl_q[`EN_SS_HI:`EN_SS_LO]; // R21
      ctrl.ilimit_sel     <= ctrl1_q[`C1_ILIM_HI:`C1_ILIM_LO]; // R6
      ctrl.thermal_reduce <= (ctrl1_q[`C1_THERM_HI:`C1_THERM_LO] != 2'b00 &&
        sense.die_temp > (8'd60 + {5'd0, ctrl1_q[`C1_THERM_HI:`C1_THERM_LO], 1'b0} * 8'd10))
        ? ctrl1_q[`C1_THERM_HI:`C1_THERM_LO] : 2'b00; // R1
      ctrl.discharge_on   <= rampcfg_q[`RC_DISCH] && (ramp_q > vout_code_q ||
                             (ctrl.discharge_on && !sense.in_regulation)); // R19
      ctrl.vout_target    <= ramp_q; // R16
      ctrl.uv_threshold   <= uv_thresh;
    end
  end

  // ==========================================================
  // checks
  standby_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    standby_force_bit_q |=> state_q == ST_STANDBY || $past(state_q) == ST_STANDBY) // R14
    else $error("left standby while forced");
  therm_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    over_temp |=> thermal_shutdown_flag_q) // R4
    else $error("shutdown flag not set");
  kick_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    kick_q |=> !kick_q && wd_sec_q == 9'd0) // R10
    else $error("kick did not restart watchdog");
  wd_standby_a: assert property (@(posedge aclk) disable iff (!aresetn)
    in_standby |=> wd_sec_q == 9'd0) // R12
    else $error("watchdog counts in standby");
  oc_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl1_q[`C1_OCDIS] |=> !oc_latch_q) // R8
    else $error("overcurrent latch held");
  conv_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_STANDBY |=> !ctrl.conv_enable) // R2
    else $error("converter on in standby");
  irq_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    in_standby && !was_standby_q |=> ##1 !interrupt_out_n) // R22
    else $error("no interrupt on standby entry");
  uv_exit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_ACTIVE && uv_trip && enabled && !standby_force_bit_q && !ov_long
    && !wd_expired_q |=> state_q == ST_DELAY) // R18
    else $error("undervoltage did not restart");
endmodule : bbsup_ctrl
`default_nettype wire

// >>> src/bbsup_defs.svh
`ifndef BBSUP_DEFS_SVH
`define BBSUP_DEFS_SVH

// ==========================================================
// register indexes; the byte address is four times the index
`define IDX_CTRL0       8'h00
`define IDX_CTRL1       8'h01
`define IDX_ENCTL       8'h0E
`define IDX_UVMARGIN    8'h0F
`define IDX_RAMPCFG     8'h10
`define IDX_VOUT_LO     8'h13
`define IDX_VOUT_HI     8'h14
`define IDX_UVBASE      8'h1A
`define IDX_STATUS      8'h30
`define IDX_INTCTL      8'h31
`define ADDR_CTRL0      (`IDX_CTRL0 << 2)
`define ADDR_CTRL1      (`IDX_CTRL1 << 2)
`define ADDR_ENCTL      (`IDX_ENCTL << 2)
`define ADDR_UVMARGIN   (`IDX_UVMARGIN << 2)
`define ADDR_RAMPCFG    (`IDX_RAMPCFG << 2)
`define ADDR_VOUT_LO    (`IDX_VOUT_LO << 2)
`define ADDR_VOUT_HI    (`IDX_VOUT_HI << 2)
`define ADDR_UVBASE     (`IDX_UVBASE << 2)
`define ADDR_STATUS     (`IDX_STATUS << 2)
`define ADDR_INTCTL     (`IDX_INTCTL << 2)

// ==========================================================
// field positions
`define C0_STANDBY      0
`define C0_KICK         1
`define C1_LDO_EN       0
`define C1_ILIM_LO      1
`define C1_ILIM_HI      2
`define C1_OCDIS        3
`define C1_WD_LO        4
`define C1_WD_HI        5
`define C1_THERM_LO     6
`define C1_THERM_HI     7
`define EN_SW_EN        0
`define EN_OVR          1
`define EN_SS_LO        2
`define EN_SS_HI        3
`define EN_START_LO     4
`define EN_START_HI     5
`define RC_SLEW_LO      0
`define RC_SLEW_HI      1
`define RC_DISCH        2
`define INT_CLEAR       0

// ==========================================================
// reset values
`define CTRL1_RST       8'h01
`define ENCTL_RST       8'h00
`define VOUT_RST        10'h0CE
`define UVBASE_RST      8'h40
`define UVMARGIN_RST    8'h04

// ==========================================================
// timing (clock 200 MHz)
`define CLK_HZ          200000000
`define OV_TIME_MS      100
`define OV_CYCLES       ((`CLK_HZ / 1000) * `OV_TIME_MS)
`define WD_UNIT_HZ      1
`define DLY_STEP_MS     1
`define RAMP_STEP_CYC   40'd4000
`define RAMP_STEP_W     40
`define TSHUT_C         8'd160
`define TSHUT_HYST_C    8'd30
`define OC_RUN_LEN      4'd8
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// >>> src/bbsup_pkg.sv
`default_nettype none
package bbsup_pkg;
  typedef enum logic [3:0] {
    ST_STANDBY = 4'b0001,
    ST_DELAY   = 4'b0010,
    ST_ACTIVE  = 4'b0100,
    ST_FAULT   = 4'b1000
  } sup_state_e;

  typedef struct packed {
    logic        sw_turn_off;
    logic        conv_enable;
    logic        ldo_enable;
    logic        soft_start;
    logic [1:0]  soft_start_sel;
    logic [1:0]  ilimit_sel;
    logic [1:0]  thermal_reduce;
    logic        discharge_on;
    logic [9:0]  vout_target;
    logic [7:0]  uv_threshold;
  } conv_ctrl_s;

  typedef struct packed {
    logic        over_current;
    logic        ov_input;
    logic        in_regulation;
    logic [7:0]  die_temp;
    logic [7:0]  vin_code;
    logic        cycle_start;
  } conv_sense_s;
endpackage : bbsup_pkg
`default_nettype wire

// >>> sim/bbsup_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// power stage stand-in: cycles, current trip, output level
module bbsup_stage_model (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire bbsup_pkg::conv_ctrl_s ctrl,
  input  wire logic                 oc_req,
  input  wire logic                 ov_req,
  input  wire logic [7:0]           temp,
  input  wire logic [7:0]           vin,
  output var  bbsup_pkg::conv_sense_s sense
);
  import bbsup_pkg::*;
  logic [2:0] ph_q;
  logic [9:0] lvl_q;
  // output moves one code per switching cycle, so regulation lags the target
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_q  <= 3'h0;
      lvl_q <= ctrl.vout_target;
    end else begin
      ph_q <= ph_q + 3'h1;
      if (ph_q == 3'h0 && lvl_q > ctrl.vout_target) lvl_q <= lvl_q - 10'h1;
      if (ph_q == 3'h0 && lvl_q < ctrl.vout_target) lvl_q <= lvl_q + 10'h1;
    end
  end
  // a stopped stage draws no current, so trips only while switching
  always_comb begin
    sense.over_current  = oc_req & ctrl.conv_enable;
    sense.ov_input      = ov_req;
    sense.in_regulation = (lvl_q == ctrl.vout_target);
    sense.die_temp      = temp;
    sense.vin_code      = vin;
    sense.cycle_start   = (ph_q == 3'h0) & aresetn;
  end
endmodule : bbsup_stage_model
`default_nettype wire

// >>> sim/buck_boost_state_and_protection_ctrl_tb.sv
`include "bbsup_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module buck_boost_state_and_protection_ctrl_tb;
  import bbsup_pkg::*;
  logic        aclk, aresetn, enable_pin, oc_req, ov_req, interrupt_out_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, temp, vin, b, m, c1;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  conv_sense_s sense;
  conv_ctrl_s  ctrl;
  int          n_fail = 0, samples_checked = 0, cycles = 0, n;
  // short second/ms ticks keep the watchdog and delays inside the run
  bbsup_ctrl #(.WD_TICK(10), .OV_LIMIT(20), .DLY_TICK(2)) dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .enable_pin, .sense, .ctrl,
    .interrupt_out_n);
  bbsup_stage_model stage_u (.aclk, .aresetn, .ctrl, .oc_req, .ov_req, .temp, .vin, .sense);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_fail++;
      print_verdict();
    end
  end
  // ==========================================
  // helpers
  task automatic print_verdict();
    $display("compares=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [1:0] exp_reduce(input logic [7:0] c, input logic [7:0] t);
    logic [7:0] lim;
    case (c[7:6])
      2'b01:   lim = 8'd80;
      2'b10:   lim = 8'd100;
      default: lim = 8'd120;
    endcase
    return (c[7:6] != 2'b00 && t > lim) ? c[7:6] : 2'b00;
  endfunction : exp_reduce
  task automatic idle(input int k);
    repeat (k) @(posedge aclk);
  endtask : idle
  task automatic wait_en(input logic v);
    n = 0;
    while (ctrl.conv_enable !== v && n < 1000) begin
      @(posedge aclk);
      n++;
    end
    chk(ctrl.conv_enable, v);
  endtask : wait_en
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd_reg
  // ==========================================
  // tests
  initial begin
    void'($urandom(32'h86b1cd6e));
    {aresetn, enable_pin, oc_req, ov_req, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    temp = 8'h19;
    vin = 8'hFF;
    idle(20);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(ctrl, '0);
    chk(interrupt_out_n, 1'b1);
    rd_reg(`ADDR_STATUS);
    chk(rd[7:4], 4'b0001);
    rd_reg(8'h80);
    chk(rsp, `RESP_SLVERR);
    chk(rd, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      c1 = {8'($urandom) & 8'hC9} | {5'h0, i[1:0], 1'b0};
      b = 8'($urandom_range(255, 128));
      m = 8'($urandom_range(127, 1));
      wr(`ADDR_CTRL1, c1);
      wr(`ADDR_UVBASE, b);
      wr(`ADDR_UVMARGIN, m);
      wr(`ADDR_ENCTL, {i[1:0], 2'b10});
      idle(2);
      chk(ctrl.ldo_enable, c1[0]);
      chk(ctrl.ilimit_sel, c1[2:1]);
      chk(ctrl.uv_threshold, b - m);
      chk(ctrl.soft_start_sel, i[1:0]);
      chk(ctrl.thermal_reduce, exp_reduce(c1, temp));
      chk(ctrl.conv_enable, 1'b0);
      rd_reg(`ADDR_CTRL1);
      chk(rd, {24'h0, c1});
    end
    $display("test config done");
    wr(`ADDR_CTRL1, 8'h01);
    wr(`ADDR_ENCTL, 8'h00);
    enable_pin <= 1'b1;
    wait_en(1'b1);
    enable_pin <= 1'b0;
    wait_en(1'b0);
    idle(2);
    chk(interrupt_out_n, 1'b0);
    wr(`ADDR_INTCTL, 8'h01);
    idle(2);
    chk(interrupt_out_n, 1'b1);
    enable_pin <= 1'b1;
    wait_en(1'b1);
    wr(`ADDR_ENCTL, 8'h02);
    wait_en(1'b0);
    wr(`ADDR_ENCTL, 8'h03);
    wait_en(1'b1);
    wr(`ADDR_CTRL0, 8'h01);
    wait_en(1'b0);
    idle(20);
    chk(ctrl.conv_enable, 1'b0);
    wr(`ADDR_CTRL0, 8'h00);
    wait_en(1'b1);
    $display("test enable done");
    wr(`ADDR_CTRL1, 8'h41);
    temp <= 8'd90;
    idle(4);
    chk(ctrl.thermal_reduce, exp_reduce(8'h41, 8'd90));
    wr(`ADDR_CTRL1, 8'h01);
    idle(4);
    chk(ctrl.thermal_reduce, 2'b00);
    temp <= 8'd160;
    idle(20);
    chk(ctrl.conv_enable, 1'b1);
    temp <= 8'd161;
    wait_en(1'b0);
    temp <= 8'd130;
    idle(50);
    chk(ctrl.conv_enable, 1'b0);
    temp <= 8'd129;
    wait_en(1'b1);
    rd_reg(`ADDR_STATUS);
    chk(rd[0], 1'b1);
    rd_reg(`ADDR_STATUS);
    chk(rd[0], 1'b0);
    $display("test thermal done");
    vin <= 8'h00;
    wait_en(1'b0);
    vin <= 8'hFF;
    wait_en(1'b1);
    ov_req <= 1'b1;
    wait_en(1'b0);
    ov_req <= 1'b0;
    wait_en(1'b1);
    idle(40);
    chk(ctrl.conv_enable, 1'b1);
    $display("test input limits done");
    oc_req <= 1'b1;
    idle(3);
    chk(ctrl.sw_turn_off, 1'b1);
    wait_en(1'b0);
    oc_req <= 1'b0;
    rd_reg(`ADDR_STATUS);
    chk(rd[1], 1'b1);
    wr(`ADDR_CTRL1, 8'h09);
    rd_reg(`ADDR_STATUS);
    chk(rd[1], 1'b0);
    wait_en(1'b1);
    oc_req <= 1'b1;
    idle(150);
    chk(ctrl.conv_enable, 1'b1);
    oc_req <= 1'b0;
    wr(`ADDR_CTRL1, 8'h01);
    $display("test overcurrent done");
    wr(`ADDR_RAMPCFG, 8'h04);
    wr(`ADDR_VOUT_LO, 8'hCD);
    idle(4);
    chk(ctrl.discharge_on, 1'b1);
    n = 0;
    while (ctrl.vout_target !== 10'h0CD && n < 45000) begin
      @(posedge aclk);
      n++;
    end
    chk(ctrl.vout_target, 10'h0CD);
    chk(ctrl.conv_enable, 1'b1);
    $display("test setpoint done");
    wr(`ADDR_CTRL1, 8'h11);
    repeat (3) begin
      idle(500);
      wr(`ADDR_CTRL0, 8'h02);
    end
    chk(ctrl.conv_enable, 1'b1);
    rd_reg(`ADDR_CTRL0);
    chk(rd[1], 1'b0);
    idle(500);
    wr(`ADDR_CTRL0, 8'h01);
    wait_en(1'b0);
    wr(`ADDR_CTRL0, 8'h00);
    wait_en(1'b1);
    wr(`ADDR_INTCTL, 8'h01);
    idle(500);
    chk(ctrl.conv_enable, 1'b1);
    wait_en(1'b0);
    rd_reg(`ADDR_STATUS);
    chk(rd[7:4], 4'b1000);
    chk(interrupt_out_n, 1'b0);
    wr(`ADDR_CTRL0, 8'h02);
    wait_en(1'b1);
    $display("test watchdog done");
    print_verdict();
  end
endmodule : buck_boost_state_and_protection_ctrl_tb
`default_nettype wire
